// ==== hdl/limit_recovery_pkg.sv ====
package limit_recovery_pkg;
	// Register offsets on the serial register port
	localparam logic [7:0] LIMIT_OFFSET = 8'h14;
	localparam logic [7:0] RECOVERY_OFFSET = 8'h15;
	localparam logic [7:0] TOTAL1_OFFSET = 8'h16;
	localparam logic [7:0] TOTAL2_OFFSET = 8'h1a;
	localparam logic [7:0] THRESH1_OFFSET = 8'h1e;
	localparam logic [7:0] THRESH2_OFFSET = 8'h20;
	localparam logic [7:0] RATION_CFG_OFFSET = 8'h22;
	// Field positions
	localparam int P1_LIMIT_LSB = 0;
	localparam int P2_LIMIT_LSB = 3;
	localparam int CYCLE_LSB = 4;
	localparam int RETRY_LSB = 2;
	localparam int RATION_EN_BIT = 0;
	localparam int RATION_CLR_BIT = 1;
	localparam int HIT1_BIT = 2;
	localparam int HIT2_BIT = 3;
	// Reset values
	localparam logic [7:0] LIMIT_RESET = 8'h00;
	localparam logic [7:0] RECOVERY_RESET = 8'h2a;
	localparam logic [15:0] THRESH_RESET = 16'hffff;
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int MS_CYCLES = CLK_MHZ * 1000;
	localparam int SEC_MS = 1000;
	localparam int RETRY_BASE_MS = 10;
	localparam int RETRY_STEP_MS = 5;
	localparam int CYCLE_BASE_MS = 15;
	localparam int CYCLE_STEP_MS = 5;
	localparam int TOTAL_WIDTH = 26;
	localparam logic [2:0] TEST_LIMIT_CODE = 3'h0;
	typedef enum logic [1:0] {PWR_SLEEP, PWR_DETECT, PWR_ACTIVE, PWR_ERROR}
		power_t;
	typedef enum {REC_IDLE, REC_WAIT, REC_CHECK, REC_TEST} recovery_t;
endpackage

// ==== hdl/port_limit_recovery_charge_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_limit_recovery_charge_regs #(
	parameter int MS_COUNT = limit_recovery_pkg::MS_CYCLES,
	parameter int SEC_COUNT = limit_recovery_pkg::SEC_MS,
	parameter int TOTAL_W = limit_recovery_pkg::TOTAL_WIDTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Device state and sensing
	input wire logic [2:0] limit_strap_pin,
	input wire limit_recovery_pkg::power_t power_state,
	input wire logic [1:0] port_fault,
	input wire logic overtemp,
	input wire logic back_drive,
	input wire logic [1:0] vbus_below_test,
	input wire logic [15:0] charge_incr_p1,
	input wire logic [15:0] charge_incr_p2,
	// Switch control
	output logic [2:0] port1_limit_sel,
	output logic [2:0] port2_limit_sel,
	output logic [1:0] switch_on,
	output logic [1:0] short_retry,
	output logic ration_hit_p1,
	output logic ration_hit_p2
);
	import limit_recovery_pkg::*;

	function automatic logic [2:0] cap_code(input logic [2:0] req,
		input logic [2:0] strap);
		cap_code = (req > strap) ? strap : req;
	endfunction
	function automatic logic [7:0] ms_to_cnt(input logic [2:0] code,
		input int base, input int step);
		ms_to_cnt = 8'(base + step * int'(code));
	endfunction
	function automatic logic at_limit(logic [TOTAL_W-1:0] t, logic [15:0] h);
		at_limit = t[TOTAL_W-1 -: 16] >= h; // One threshold step is 1024 counts
	endfunction

	logic [7:0] limit_reg, limit_next;
	logic [7:0] recovery_reg, recovery_next;
	logic [15:0] thresh1_reg, thresh1_next, thresh2_reg, thresh2_next;
	logic ration_en_reg, ration_en_next;
	logic hit1_reg, hit1_next, hit2_reg, hit2_next;
	logic [TOTAL_W-1:0] total1_reg, total1_next, total2_reg, total2_next;
	logic [31:0] ms_cnt_reg, ms_cnt_next;
	logic [15:0] sec_cnt_reg, sec_cnt_next;
	logic strap_loaded_reg, strap_loaded_next;
	logic [7:0] rdata_next;
	logic sec_tick, ms_tick;
	logic ration_clear;
	logic [TOTAL_W-1:0] sum1, sum2;

	// 26-bit totals and register file; no power state clears them
	always_comb begin
		limit_next = limit_reg;
		recovery_next = recovery_reg;
		thresh1_next = thresh1_reg;
		thresh2_next = thresh2_reg;
		ration_en_next = ration_en_reg;
		strap_loaded_next = 1'b1;
		ration_clear = 1'b0;
		sum1 = total1_reg + TOTAL_W'(charge_incr_p1);
		sum2 = total2_reg + TOTAL_W'(charge_incr_p2);
		if (!strap_loaded_reg) begin
			limit_next = {2'b00, limit_strap_pin, limit_strap_pin};
		end
		if (reg_wr) begin
			unique case (reg_addr)
				LIMIT_OFFSET: begin
					limit_next[P2_LIMIT_LSB +: 3] =
						cap_code(reg_wdata[5:3], limit_strap_pin);
					limit_next[P1_LIMIT_LSB +: 3] =
						cap_code(reg_wdata[2:0], limit_strap_pin);
				end
				RECOVERY_OFFSET: recovery_next = reg_wdata;
				THRESH1_OFFSET: thresh1_next[15:8] = reg_wdata;
				THRESH1_OFFSET + 8'h01: thresh1_next[7:0] = reg_wdata;
				THRESH2_OFFSET: thresh2_next[15:8] = reg_wdata;
				THRESH2_OFFSET + 8'h01: thresh2_next[7:0] = reg_wdata;
				RATION_CFG_OFFSET: begin
					ration_en_next = reg_wdata[RATION_EN_BIT];
					ration_clear = reg_wdata[RATION_CLR_BIT] || !reg_wdata[RATION_EN_BIT];
				end
				default: ;
			endcase
		end
		total1_next = total1_reg;
		total2_next = total2_reg;
		hit1_next = hit1_reg;
		hit2_next = hit2_reg;
		if (sec_tick && power_state == PWR_ACTIVE && ration_en_reg) begin
			total1_next = sum1;
			total2_next = sum2;
			if (at_limit(sum1, thresh1_reg)) begin
				hit1_next = 1'b1;
			end
			if (at_limit(sum2, thresh2_reg)) begin
				hit2_next = 1'b1;
			end
		end
		if (ration_clear) begin
			total1_next = '0;
			total2_next = '0;
			hit1_next = 1'b0;
			hit2_next = 1'b0;
		end
	end

	// Register update; nothing keyed to Sleep
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			limit_reg <= LIMIT_RESET;
			recovery_reg <= RECOVERY_RESET;
			thresh1_reg <= THRESH_RESET;
			thresh2_reg <= THRESH_RESET;
			ration_en_reg <= 1'b0;
			hit1_reg <= 1'b0;
			hit2_reg <= 1'b0;
			total1_reg <= '0;
			total2_reg <= '0;
			strap_loaded_reg <= 1'b0;
		end else begin
			limit_reg <= limit_next;
			recovery_reg <= recovery_next;
			thresh1_reg <= thresh1_next;
			thresh2_reg <= thresh2_next;
			ration_en_reg <= ration_en_next;
			hit1_reg <= hit1_next;
			hit2_reg <= hit2_next;
			total1_reg <= total1_next;
			total2_reg <= total2_next;
			strap_loaded_reg <= strap_loaded_next;
		end
	end
	// Millisecond and second enables from one divider
	always_comb begin
		ms_cnt_next = ms_cnt_reg + 32'h1;
		sec_cnt_next = sec_cnt_reg;
		sec_tick = 1'b0;
		ms_tick = (ms_cnt_reg == 32'(MS_COUNT - 1));
		if (ms_tick) begin
			ms_cnt_next = '0;
			sec_cnt_next = sec_cnt_reg + 16'h1;
			if (sec_cnt_reg == 16'(SEC_COUNT - 1)) begin
				sec_cnt_next = '0;
				sec_tick = 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ms_cnt_reg <= '0;
			sec_cnt_reg <= '0;
		end else begin
			ms_cnt_reg <= ms_cnt_next;
			sec_cnt_reg <= sec_cnt_next;
		end
	end

	// Per-port recovery sequencer
	recovery_t rec_reg [2], rec_next [2];
	logic [7:0] rec_cnt_reg [2], rec_cnt_next [2];
	logic [1:0] sw_next, retry_next;
	logic [2:0] lim_next [2];
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			rec_next[p] = rec_reg[p];
			rec_cnt_next[p] = rec_cnt_reg[p];
			sw_next[p] = 1'b1;
			retry_next[p] = 1'b0;
			lim_next[p] = (p == 0) ? limit_reg[2:0] : limit_reg[5:3];
			if (ms_tick && rec_cnt_reg[p] != 8'h0) begin
				rec_cnt_next[p] = rec_cnt_reg[p] - 8'h1;
			end
			unique case (rec_reg[p])
				REC_IDLE: begin
					if (port_fault[p]) begin
						rec_next[p] = REC_WAIT;
						rec_cnt_next[p] = ms_to_cnt(
							recovery_reg[CYCLE_LSB +: 3],
							CYCLE_BASE_MS, CYCLE_STEP_MS);
						sw_next[p] = 1'b0;
					end
				end
				REC_WAIT: begin
					sw_next[p] = 1'b0;
					if (rec_cnt_reg[p] == 8'h0) begin
						rec_next[p] = REC_CHECK;
					end
				end
				REC_CHECK: begin
					sw_next[p] = 1'b0;
					if (!overtemp && !back_drive) begin
						rec_next[p] = REC_TEST;
						lim_next[p] = TEST_LIMIT_CODE;
						rec_cnt_next[p] = ms_to_cnt(
							{1'b0, recovery_reg[RETRY_LSB +: 2]},
							RETRY_BASE_MS, RETRY_STEP_MS);
						sw_next[p] = 1'b1;
					end
				end
				REC_TEST: begin
					lim_next[p] = TEST_LIMIT_CODE;
					if (rec_cnt_reg[p] == 8'h0) begin
						if (vbus_below_test[p]) begin
							rec_next[p] = REC_WAIT;
							rec_cnt_next[p] = ms_to_cnt(
								recovery_reg[CYCLE_LSB +: 3],
								CYCLE_BASE_MS, CYCLE_STEP_MS);
							sw_next[p] = 1'b0;
							retry_next[p] = 1'b1;
						end else begin
							rec_next[p] = REC_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Register read data; top limit bits read zero
	always_comb begin
		unique case (reg_addr)
			LIMIT_OFFSET: rdata_next = {2'b00, limit_reg[5:0]};
			RECOVERY_OFFSET: rdata_next = recovery_reg;
			TOTAL1_OFFSET: rdata_next = total1_reg[25:18];
			TOTAL1_OFFSET + 8'h01: rdata_next = total1_reg[17:10];
			TOTAL1_OFFSET + 8'h02: rdata_next = total1_reg[9:2];
			TOTAL1_OFFSET + 8'h03: rdata_next = {total1_reg[1:0], 6'h00};
			TOTAL2_OFFSET: rdata_next = total2_reg[25:18];
			TOTAL2_OFFSET + 8'h01: rdata_next = total2_reg[17:10];
			TOTAL2_OFFSET + 8'h02: rdata_next = total2_reg[9:2];
			TOTAL2_OFFSET + 8'h03: rdata_next = {total2_reg[1:0], 6'h00};
			THRESH1_OFFSET: rdata_next = thresh1_reg[15:8];
			THRESH1_OFFSET + 8'h01: rdata_next = thresh1_reg[7:0];
			THRESH2_OFFSET: rdata_next = thresh2_reg[15:8];
			THRESH2_OFFSET + 8'h01: rdata_next = thresh2_reg[7:0];
			RATION_CFG_OFFSET: rdata_next = {4'h0, hit2_reg, hit1_reg,
				1'b0, ration_en_reg};
			default: rdata_next = 8'h00;
		endcase
	end

	// Outputs registered; limit codes drive the switches
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rec_reg[0] <= REC_IDLE;
			rec_reg[1] <= REC_IDLE;
			rec_cnt_reg[0] <= 8'h0;
			rec_cnt_reg[1] <= 8'h0;
			reg_rdata <= 8'h00;
			port1_limit_sel <= 3'h0;
			port2_limit_sel <= 3'h0;
			switch_on <= 2'b00;
			short_retry <= 2'b00;
			ration_hit_p1 <= 1'b0;
			ration_hit_p2 <= 1'b0;
		end else begin
			rec_reg[0] <= rec_next[0];
			rec_reg[1] <= rec_next[1];
			rec_cnt_reg[0] <= rec_cnt_next[0];
			rec_cnt_reg[1] <= rec_cnt_next[1];
			reg_rdata <= reg_rd ? rdata_next : reg_rdata;
			port1_limit_sel <= lim_next[0];
			port2_limit_sel <= lim_next[1];
			switch_on <= sw_next;
			short_retry <= retry_next;
			ration_hit_p1 <= hit1_next;
			ration_hit_p2 <= hit2_next;
		end
	end
	// Checks
	limit_capped_a: assert property (@(posedge clk) disable iff (sys_rst)
		strap_loaded_reg |-> limit_reg[2:0] <= limit_strap_pin)
		else $error("port1 limit above strap");
	upper_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == LIMIT_OFFSET |=> reg_rdata[7:6] == 2'b00)
		else $error("limit upper bits not zero");
	hold_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
		power_state != PWR_ACTIVE && !(reg_wr && reg_addr == RATION_CFG_OFFSET)
		|=> $stable(total1_reg))
		else $error("total moved outside Active");
	test_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
		rec_reg[0] == REC_CHECK && (overtemp || back_drive)
		|=> rec_reg[0] == REC_CHECK)
		else $error("test began during fault check");
	test_start_a: assert property (@(posedge clk) disable iff (sys_rst)
		rec_reg[0] == REC_CHECK && rec_next[0] == REC_TEST
		|=> switch_on[0] && port1_limit_sel == TEST_LIMIT_CODE)
		else $error("switch and test current not together");
	short_retry_a: assert property (@(posedge clk) disable iff (sys_rst)
		rec_reg[0] == REC_TEST && rec_cnt_reg[0] == 8'h0 && vbus_below_test[0]
		|=> rec_reg[0] == REC_WAIT && short_retry[0])
		else $error("short not retried");
	clear_only_a: assert property (@(posedge clk) disable iff (sys_rst)
		ration_clear |=> total1_reg == '0 && total2_reg == '0)
		else $error("ration clear missed");
	hit_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		sec_tick && power_state == PWR_ACTIVE && ration_en_reg
		&& !(reg_wr && reg_addr == RATION_CFG_OFFSET)
		&& at_limit(sum1, thresh1_reg) |=> hit1_reg)
		else $error("ration hit not set");
endmodule
`default_nettype wire

// ==== tb/portable_device_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module portable_device_model (
	// Bench control
	input wire logic [1:0] shorted,
	input wire logic [15:0] load_p1,
	input wire logic [15:0] load_p2,
	// Switch side
	input wire logic [1:0] switch_on,
	output logic [1:0] vbus_below_test,
	output logic [15:0] charge_incr_p1,
	output logic [15:0] charge_incr_p2
);
	// Bus sags with the switch open or a short on it
	assign vbus_below_test = ~switch_on | shorted;
	// Steady load, so every update adds the same charge
	assign charge_incr_p1 = load_p1;
	assign charge_incr_p2 = load_p2;
endmodule
`default_nettype wire

// ==== tb/port_limit_recovery_charge_regs_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("unexpected t=%0t got %0h want %0h", $time, a, e); end end
module port_limit_recovery_charge_regs_tb_top;
	import limit_recovery_pkg::*;
	localparam int MS = 10;
	localparam int SEC = 2;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [2:0] strap = 3'h5;
	power_t pstate = PWR_SLEEP;
	logic [1:0] port_fault = 2'b00;
	logic overtemp = 1'b0;
	logic back_drive = 1'b0;
	logic [1:0] shorted = 2'b00;
	logic [15:0] load1 = 16'h0100;
	logic [15:0] load2 = 16'h0200;
	logic [1:0] vbus_below, sw_on, short_retry;
	logic [15:0] incr1, incr2;
	logic [2:0] sel1, sel2;
	logic hit1, hit2;
	int fail_count = 0;
	int num_checks = 0;
	integer seed = 32'h7554;
	// Fast ms and s counts keep the run short
	port_limit_recovery_charge_regs #(.MS_COUNT(MS), .SEC_COUNT(SEC))
	port_limit_recovery_charge_regs_i (.clk(clk), .sys_rst(sys_rst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.limit_strap_pin(strap), .power_state(pstate),
		.port_fault(port_fault), .overtemp(overtemp),
		.back_drive(back_drive), .vbus_below_test(vbus_below),
		.charge_incr_p1(incr1), .charge_incr_p2(incr2),
		.port1_limit_sel(sel1), .port2_limit_sel(sel2),
		.switch_on(sw_on), .short_retry(short_retry),
		.ration_hit_p1(hit1), .ration_hit_p2(hit2));
	portable_device_model portable_device_model_i (.shorted(shorted),
		.load_p1(load1), .load_p2(load2), .switch_on(sw_on),
		.vbus_below_test(vbus_below), .charge_incr_p1(incr1),
		.charge_incr_p2(incr2));
	always #5 clk = ~clk;
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Data lands one edge after the read edge
	task automatic rd(logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	task automatic rd_total(logic [7:0] a, output logic [25:0] t);
		logic [7:0] b0, b1, b2, b3;
		rd(a, b0);
		rd(a + 8'h1, b1);
		rd(a + 8'h2, b2);
		rd(a + 8'h3, b3);
		t = {b0, b1, b2, b3[7:6]};
		`CHK(b3[5:0], 6'h00)
	endtask
	task automatic do_reset();
		@(posedge clk);
		sys_rst <= 1'b1;
		tick(8);
		sys_rst <= 1'b0;
		tick(2);
	endtask
	// Bounded wait on port 1: switch back on once opened, or a short pulse
	task automatic wait_on(bit pulse, int lim, output int n);
		bit low;
		n = 0;
		low = pulse || sw_on[0] === 1'b0;
		while (!low || (pulse ? short_retry[0] : sw_on[0]) !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (sw_on[0] === 1'b0) begin
				low = 1'b1;
			end
			if (n > lim) begin
				fail_count++;
				conclude();
			end
		end
	endtask
	function automatic logic [7:0] exp_lim(logic [7:0] w, logic [2:0] s);
		return {2'b00, (w[5:3] > s) ? s : w[5:3], (w[2:0] > s) ? s : w[2:0]};
	endfunction
	initial begin
		logic [7:0] d, w, e;
		logic [25:0] t1, t2;
		int n;
		do_reset();
		rd(LIMIT_OFFSET, d);
		`CHK(d, {2'b00, strap, strap})
		// Corners first, then random codes, all in Sleep
		for (int i = 0; i < 12; i++) begin
			w = (i == 0) ? 8'hff : (i == 1) ? 8'h24 : 8'($random(seed));
			e = exp_lim(w, strap);
			wr(LIMIT_OFFSET, w);
			rd(LIMIT_OFFSET, d);
			`CHK(d, e)
			`CHK(sel1, e[2:0])
			`CHK(sel2, e[5:3])
		end
		rd(RECOVERY_OFFSET, d);
		`CHK(d, RECOVERY_RESET)
		rd(8'h40, d);
		`CHK(d, 8'h00)
		// Cycle codes 4 to 7 and each retry code, bus shorted throughout
		for (int i = 0; i < 4; i++) begin
			do_reset();
			wr(RECOVERY_OFFSET, {1'b0, 3'(4 + i), 2'(i), 2'b00});
			port_fault <= 2'b01;
			shorted <= 2'b01;
			wait_on(0, 1000, n);
			// Ms ticks run at a free phase, plus three edges of pipeline
			`CHK((n + MS - 4) / MS, 15 + 5 * (4 + i))
			`CHK(sel1, TEST_LIMIT_CODE)
			wait_on(1, 400, n);
			`CHK((n + MS / 2) / MS, 10 + 5 * i)
			tick(2);
			`CHK(sw_on[0], 1'b0)
			`CHK({sw_on[1], short_retry[1]}, 2'b10)
			port_fault <= 2'b00;
			shorted <= 2'b00;
		end
		// Overtemperature holds the retry back
		do_reset();
		overtemp <= 1'b1;
		port_fault <= 2'b01;
		tick(700);
		`CHK(sw_on[0], 1'b0)
		overtemp <= 1'b0;
		wait_on(0, 700, n);
		`CHK(n, 1)
		port_fault <= 2'b00;
		// Charge totals across Active and Sleep
		do_reset();
		load1 <= 16'h0100 | 16'($random(seed));
		load2 <= 16'h0001 | 16'($random(seed));
		wr(RATION_CFG_OFFSET, 8'h01);
		pstate <= PWR_ACTIVE;
		tick(10 * SEC * MS);
		pstate <= PWR_SLEEP;
		wr(TOTAL1_OFFSET, 8'hff);
		rd_total(TOTAL1_OFFSET, t1);
		`CHK(t1 % load1, 26'h0)
		`CHK(t1 / load1 inside {[9:11]}, 1'b1)
		tick(100);
		rd_total(TOTAL1_OFFSET, t2);
		`CHK(t2, t1)
		pstate <= PWR_ACTIVE;
		tick(5 * SEC * MS);
		pstate <= PWR_SLEEP;
		rd_total(TOTAL1_OFFSET, t2);
		`CHK((t2 - t1) / load1 inside {[4:6]}, 1'b1)
		rd_total(TOTAL2_OFFSET, t2);
		`CHK(t2 % load2, 26'h0)
		wr(THRESH1_OFFSET, 8'h00);
		wr(THRESH1_OFFSET + 8'h1, 8'h00);
		pstate <= PWR_ACTIVE;
		tick(3 * SEC * MS);
		pstate <= PWR_SLEEP;
		rd(RATION_CFG_OFFSET, d);
		`CHK(hit1, 1'b1)
		`CHK(hit2, 1'b0)
		`CHK(d[HIT1_BIT], 1'b1)
		`CHK(d[HIT2_BIT], 1'b0)
		wr(RATION_CFG_OFFSET, 8'h03);
		rd_total(TOTAL1_OFFSET, t1);
		`CHK(t1, 26'h0)
		pstate <= PWR_ACTIVE;
		tick(3 * SEC * MS);
		pstate <= PWR_SLEEP;
		rd_total(TOTAL1_OFFSET, t1);
		`CHK(t1 != 26'h0, 1'b1)
		wr(RATION_CFG_OFFSET, 8'h00);
		rd_total(TOTAL1_OFFSET, t1);
		`CHK(t1, 26'h0)
		conclude();
	end
endmodule
`default_nettype wire
